/* bench/sci_host_model.sv */
// host controller model: drives select, link clock and serial input
// assumes the bench calls frame and reads rxWord when frameDone toggles
`timescale 1ns/1ps
`default_nettype none
module sci_host_model (
    output logic sck,
    output logic csN,
    output logic sdi,
    output logic probe,
    output logic frameDone,
    output logic [31:0] rxWord,
    input wire logic sdo,
    input wire logic sdoOeN
);
    logic lastSdo;
    initial begin
        {sck, sdi, probe, frameDone, lastSdo} = 5'h0;
        csN = 1'b1;
        rxWord = 32'h0;
    end
    task frame(input logic cpol, input logic [31:0] tx, input int nbits);
        rxWord = 32'h0;
        sck = cpol;
        #3;
        csN = 1'b0;
        #3.1;
        for (int i = nbits - 1; i >= 0; i--) begin
            sck = 1'b0;
            sdi = tx[i];
            #2;
            probe = 1'b1;
            #1;
            sck = 1'b1;
            lastSdo = sdoOeN ? ~lastSdo : sdo;
            rxWord = {rxWord[30:0], lastSdo};
            probe = 1'b0;
            #3;
        end
        sck = cpol;
        #3;
        csN = 1'b1;
        sdi = ~sdi;
        frameDone = ~frameDone;
        #400;
    endtask : frame
endmodule : sci_host_model
`default_nettype wire

/* bench/sci_spi_cmd_sva.sv */
// checker of the command interpreter, seeing only its ports
// assumes the bind at the foot onto every sci_spi_cmd
`timescale 1ns/1ps
`default_nettype none
module sci_spi_cmd_chk (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic csN,
    input wire logic sdo,
    input wire logic sdoOeN,
    input wire logic regWrEn,
    input wire logic [7:0] regWrAddr,
    input wire logic [2:0] operatingModeField,
    input wire logic softReset,
    input wire logic [2:0] rtsSet,
    input wire logic [1:0] rxFlagClear
);
    property p_oe;
        @(posedge mclk) disable iff (sys_rst) sdoOeN == csN;
    endproperty
    a_oe: assert property (p_oe) else $error("enable not select");
    property p_idle;
        @(posedge mclk) disable iff (sys_rst) csN |-> !sdo;
    endproperty
    a_idle: assert property (p_idle) else $error("sdo busy idle");
    property p_soft_pulse;
        @(posedge mclk) disable iff (sys_rst) softReset |=> !softReset;
    endproperty
    a_soft_pulse: assert property (p_soft_pulse) else $error("long reset");
    property p_soft_mode;
        @(posedge mclk) disable iff (sys_rst)
            softReset |-> ##[0:1] operatingModeField == 3'h4;
    endproperty
    a_soft_mode: assert property (p_soft_mode) else $error("mode");
    property p_rts_end;
        @(posedge mclk) disable iff (sys_rst)
            rtsSet != 3'h0 |-> csN && $past(csN, 2);
    endproperty
    a_rts_end: assert property (p_rts_end) else $error("early send");
    property p_clr_end;
        @(posedge mclk) disable iff (sys_rst)
            rxFlagClear != 2'h0 |-> $onehot(rxFlagClear) && csN;
    endproperty
    a_clr_end: assert property (p_clr_end) else $error("bad clear");
    property p_wr_pulse;
        @(posedge sck) disable iff (csN) regWrEn |=> !regWrEn;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("long write");
    property p_wr_next;
        @(posedge sck) disable iff (csN)
            regWrEn ##8 regWrEn |-> regWrAddr == $past(regWrAddr, 8) + 8'h1;
    endproperty
    a_wr_next: assert property (p_wr_next) else $error("address");
endmodule : sci_spi_cmd_chk
bind sci_spi_cmd sci_spi_cmd_chk chk_u (.mclk(mclk), .sys_rst(sys_rst),
    .sck(sck), .csN(csN), .sdo(sdo), .sdoOeN(sdoOeN), .regWrEn(regWrEn),
    .regWrAddr(regWrAddr), .operatingModeField(operatingModeField),
    .softReset(softReset), .rtsSet(rtsSet), .rxFlagClear(rxFlagClear));
`default_nettype wire

/* bench/tb.sv */
// self-checking bench of the command interpreter with a host model
// assumes the checker binds itself; register file modelled here
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic cpol = 1'b0;
    logic sck, csN, sdi, probe, frameDone, sdo, sdoOeN, regWrEn, softRst;
    logic [31:0] rxWord;
    logic [7:0] regRdAddr, regRdData, regWrAddr, regWrData, regWrMask;
    logic [7:0] p, d1, d2, s, q;
    logic [1:0] full = 2'h0, ext = 2'h0, rtr = 2'h0, rxClr;
    logic [2:0] req = 3'h0, emp = 3'h0, hit0 = 3'h0, hit1 = 3'h0;
    logic [2:0] modeReq = 3'h0, mode, rts;
    logic modeLd = 1'b0, roll = 1'b0;
    logic [7:0] rxPtr [4] = '{8'h61, 8'h66, 8'h71, 8'h76};
    logic [7:0] txPtr [6] = '{8'h31, 8'h36, 8'h41, 8'h46, 8'h51, 8'h56};
    int err_total = 0, n_compared = 0, cyc = 0, seed = 79250, k;
    logic [23:0] wrQ[$];
    logic [31:0] rdQ[$];
    logic [5:0] evQ[$];
    assign regRdData = regRdAddr ^ 8'ha5;
    initial begin
        forever #20 mclk = ~mclk;
    end
    sci_spi_cmd dut_u (.mclk(mclk), .sys_rst(sys_rst), .sck(sck),
        .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOeN(sdoOeN),
        .regRdAddr(regRdAddr), .regRdData(regRdData), .regWrEn(regWrEn),
        .regWrAddr(regWrAddr), .regWrData(regWrData),
        .regWrMask(regWrMask), .rxBufferFullFlag(full),
        .transmitRequestBit(req), .txBufferEmpty(emp), .rxExtended(ext),
        .rxRemote(rtr), .rxFilterHitZero(hit0), .rxFilterHitOne(hit1),
        .rxRollover(roll), .modeLoad(modeLd), .modeRequest(modeReq),
        .operatingModeField(mode), .softReset(softRst), .rtsSet(rts),
        .rxFlagClear(rxClr));
    sci_host_model host_u (.sck(sck), .csN(csN), .sdi(sdi), .probe(probe),
        .frameDone(frameDone), .rxWord(rxWord), .sdo(sdo), .sdoOeN(sdoOeN));
    task summarize();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task tally(input logic ok, input string m);
        n_compared++;
        if (!ok) begin
            err_total++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : tally
    task cmp_wr(input logic [23:0] g, e);
        tally(g === e, "register write");
    endtask : cmp_wr
    task cmp_rd(input logic [31:0] g, e);
        tally(g === e, "serial output");
    endtask : cmp_rd
    task cmp_ev(input logic [5:0] g, e);
        tally(g === e, "frame event");
    endtask : cmp_ev
    task cmp_md(input logic [2:0] g, e);
        tally(g === e, "mode field");
    endtask : cmp_md
    task run(input logic [31:0] tx, input int n, input logic [31:0] rx);
        rdQ.push_back(rx);
        @(posedge mclk);
        cpol = ~cpol;
        host_u.frame(cpol, tx, n);
    endtask : run
    always @(posedge probe) begin
        if (regWrEn === 1'b1) begin
            if (wrQ.size() == 0) tally(1'b0, "stray write");
            else cmp_wr({regWrAddr, regWrData, regWrMask}, wrQ.pop_front());
        end
    end
    always @(frameDone) begin
        if (rdQ.size() != 0) cmp_rd(rxWord, rdQ.pop_front());
    end
    always @(negedge mclk) begin
        if (!sys_rst && {softRst, rts, rxClr} !== 6'h0) begin
            if (evQ.size() == 0) tally(1'b0, "stray event");
            else cmp_ev({softRst, rts, rxClr}, evQ.pop_front());
        end
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            tally(1'b0, "timeout");
            summarize();
        end
    end
    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (3) @(negedge mclk);
        cmp_md(mode, 3'h4);
        @(posedge mclk);
        modeLd <= 1'b1;
        modeReq <= 3'h2;
        @(posedge mclk);
        modeLd <= 1'b0;
        @(negedge mclk);
        cmp_md(mode, 3'h2);
        evQ.push_back(6'h20);
        run(32'hc0, 8, 32'h0);
        @(negedge mclk);
        cmp_md(mode, 3'h4);
        run(32'hc000, 16, 32'h0);
        run(32'hff5a, 16, 32'h0);
        wrQ.push_back(24'h2b3cff);
        run(32'h022b3c9, 28, 32'h0);
        run(32'h03100000, 32, 32'hb5b4);
        for (k = 0; k < 4; k++) begin
            p = rxPtr[k];
            evQ.push_back(k[1] ? 6'h2 : 6'h1);
            run({8'h0, 8'h90 | {5'h0, k[1:0], 1'b0}, 16'h0}, 24,
                {16'h0, p ^ 8'ha5, (p + 8'h1) ^ 8'ha5});
        end
        for (k = 0; k < 6; k++) begin
            p = txPtr[k];
            d1 = $random(seed);
            d2 = $random(seed);
            wrQ.push_back({p, d1, 8'hff});
            wrQ.push_back({p + 8'h1, d2, 8'hff});
            run({8'h0, 8'h40 | k[7:0], d1, d2}, 24, 32'h0);
        end
        for (k = 0; k < 8; k++) begin
            if (k != 0) evQ.push_back({1'b0, k[2:0], 2'h0});
            run({24'h0, 8'h80 | k[7:0]}, 8, 32'h0);
        end
        for (k = 0; k < 2; k++) begin
            p = k ? 8'h31 : 8'h2c;
            d1 = $random(seed);
            d2 = $random(seed);
            wrQ.push_back({p, d2, k ? 8'hff : d1});
            run({8'h05, p, d1, d2}, 32, 32'h0);
        end
        for (k = 0; k < 4; k++) begin
            @(posedge mclk);
            full <= 2'((k % 3) + 1);
            roll <= (k == 1);
            {ext, rtr, req, emp} <= 10'($random(seed));
            hit0 <= 3'($unsigned($random(seed)) % 6);
            hit1 <= 3'($unsigned($random(seed)) % 6);
            repeat (4) @(negedge mclk);
            s = {emp[2], req[2], emp[1], req[1], emp[0], req[0], full};
            q = full[0] ? {full, 1'b0, ext[0], rtr[0], hit0}
                        : {full, 1'b0, ext[1], rtr[1],
                           roll ? {2'h3, hit1[0]} : hit1};
            run({8'h0, 8'ha0, 16'h0}, 24, {16'h0, s, s});
            run({8'h0, 8'hb0, 16'h0}, 24, {16'h0, q, q});
        end
        repeat (20) @(posedge mclk);
        tally(wrQ.size() + evQ.size() + rdQ.size() == 0, "unmatched notes");
        summarize();
    end
endmodule : tb
`default_nettype wire

/* design/sci_spi_cmd.sv */
// spi target command interpreter: decodes instructions on the serial link,
// drives a register port on the link clock and frame-end events on mclk
// assumes the register file answers regRdData combinationally from
// regRdAddr in the sck domain and takes writes on the rising sck edge
`timescale 1ns/1ps
`default_nettype none
`include "sci_defs.svh"

module sci_spi_cmd
    import sci_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic csN,
    input wire logic sdi,
    output var logic sdo,
    output logic sdoOeN,
    output logic [7:0] regRdAddr,
    input wire logic [7:0] regRdData,
    output logic regWrEn,
    output logic [7:0] regWrAddr,
    output logic [7:0] regWrData,
    output logic [7:0] regWrMask,
    input wire logic [1:0] rxBufferFullFlag,
    input wire logic [2:0] transmitRequestBit,
    input wire logic [2:0] txBufferEmpty,
    input wire logic [1:0] rxExtended,
    input wire logic [1:0] rxRemote,
    input wire logic [2:0] rxFilterHitZero,
    input wire logic [2:0] rxFilterHitOne,
    input wire logic rxRollover,
    input wire logic modeLoad,
    input wire logic [2:0] modeRequest,
    output logic [2:0] operatingModeField,
    output logic softReset,
    output logic [2:0] rtsSet,
    output logic [1:0] rxFlagClear
);

    localparam sci_link_t LINK_RESET = '{
        phase: SCI_PH_CMD,
        cmd: SCI_CMD_NONE,
        bitCnt: 3'h0,
        shift: 7'h00,
        addrPtr: 8'h00,
        mask: `SCI_MASK_ALL,
        outByte: 8'h00,
        statSync1: 16'h0000,
        statSync2: 16'h0000
    };

    localparam sci_sys_t SYS_RESET = '{
        csSync1: 1'b1,
        csSync2: 1'b1,
        csPrev: 1'b1,
        sumSync1: '0,
        sumSync2: '0,
        statusByte: 8'h00,
        rxStatusByte: 8'h00,
        operatingModeField: `SCI_MODE_CONFIG,
        softReset: 1'b0,
        rtsSet: 3'h0,
        rxFlagClear: 2'h0
    };

    function automatic logic bitModifiable(input logic [7:0] a);
        bitModifiable = (a == `SCI_BM_PIN_CTRL) || (a == `SCI_BM_RTS_CTRL)
            || (a[3:0] == `SCI_BM_CTRL_LO)
            || (a >= `SCI_BM_CFG_FIRST && a <= `SCI_BM_CFG_LAST)
            || (a[3:0] == `SCI_BM_BUF_LO && a[7:4] >= `SCI_BM_BUF_FIRST
                && a[7:4] <= `SCI_BM_BUF_LAST);
    endfunction : bitModifiable

    sci_link_t lnk;
    sci_link_t next_lnk;
    sci_sum_t sum;
    sci_sum_t next_sum;
    sci_sys_t sys;
    sci_sys_t next_sys;
    logic [7:0] inByte;
    logic lastBit;

    assign inByte = {lnk.shift, sdi};
    assign lastBit = (lnk.bitCnt == 3'h7);

    // link side: rising sck edges, cleared while deselected
    always_comb begin
        next_lnk = lnk;
        next_lnk.bitCnt = lnk.bitCnt + 3'h1;
        next_lnk.shift = {lnk.shift[5:0], sdi};
        next_lnk.statSync1 = {sys.rxStatusByte, sys.statusByte};
        next_lnk.statSync2 = lnk.statSync1;
        if (lastBit) begin
            unique case (lnk.phase)
                SCI_PH_CMD: begin
                    next_lnk.mask = `SCI_MASK_ALL;
                    next_lnk.phase = SCI_PH_HOLD;
                    if (inByte == `SCI_INS_READ) begin
                        next_lnk.cmd = SCI_CMD_READ;
                        next_lnk.phase = SCI_PH_ADDR;
                    end else if (inByte == `SCI_INS_WRITE) begin
                        next_lnk.cmd = SCI_CMD_WRITE;
                        next_lnk.phase = SCI_PH_ADDR;
                    end else if (inByte == `SCI_INS_BITMOD) begin
                        next_lnk.cmd = SCI_CMD_BITMOD;
                        next_lnk.phase = SCI_PH_ADDR;
                    end else if ((inByte & `SCI_INS_RDRX_MASK)
                            == `SCI_INS_RDRX) begin
                        next_lnk.cmd = SCI_CMD_READ;
                        next_lnk.phase = SCI_PH_READ;
                        next_lnk.addrPtr = {`SCI_PTR_RX_HI, inByte[2],
                            inByte[1] ? `SCI_PTR_DATA_LO
                                      : `SCI_PTR_ID_LO};
                    end else if ((inByte & `SCI_INS_GRP_MASK)
                            == `SCI_INS_LDTX
                            && inByte[2:1] != `SCI_TX_SEL_BAD) begin
                        next_lnk.cmd = SCI_CMD_WRITE;
                        next_lnk.phase = SCI_PH_DATA;
                        next_lnk.addrPtr = {
                            4'({2'h0, inByte[2:1]} + `SCI_PTR_TX_HI),
                            inByte[0] ? `SCI_PTR_DATA_LO
                                      : `SCI_PTR_ID_LO};
                    end else if (inByte == `SCI_INS_STAT) begin
                        next_lnk.phase = SCI_PH_STAT;
                        next_lnk.outByte = lnk.statSync2[7:0];
                    end else if (inByte == `SCI_INS_RXST) begin
                        next_lnk.phase = SCI_PH_RXST;
                        next_lnk.outByte = lnk.statSync2[15:8];
                    end
                end
                SCI_PH_ADDR: begin
                    next_lnk.addrPtr = inByte;
                    if (lnk.cmd == SCI_CMD_READ) begin
                        next_lnk.phase = SCI_PH_READ;
                    end else if (lnk.cmd == SCI_CMD_BITMOD) begin
                        next_lnk.phase = SCI_PH_MASK;
                    end else begin
                        next_lnk.phase = SCI_PH_DATA;
                    end
                end
                SCI_PH_MASK: begin
                    next_lnk.mask = bitModifiable(lnk.addrPtr) ? inByte
                                  : `SCI_MASK_ALL;
                    next_lnk.phase = SCI_PH_DATA;
                end
                SCI_PH_DATA: begin
                    next_lnk.addrPtr = lnk.addrPtr + 8'h01;
                    if (lnk.cmd == SCI_CMD_BITMOD) begin
                        next_lnk.phase = SCI_PH_HOLD;
                    end
                end
                SCI_PH_READ: begin
                    next_lnk.addrPtr = lnk.addrPtr + 8'h01;
                end
                SCI_PH_STAT: begin
                    next_lnk.outByte = lnk.statSync2[7:0];
                end
                SCI_PH_RXST: begin
                    next_lnk.outByte = lnk.outByte;
                end
                SCI_PH_HOLD: begin
                    next_lnk.phase = SCI_PH_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            lnk <= LINK_RESET;
        end else begin
            lnk <= next_lnk;
        end
    end

    // frame summary survives deselect; the first edge of a frame clears it
    always_comb begin
        next_sum = sum;
        if (lnk.phase == SCI_PH_CMD && lnk.bitCnt == 3'h0) begin
            next_sum = '0;
        end else if (lnk.phase == SCI_PH_CMD && lastBit) begin
            next_sum.resetAlone = (inByte == `SCI_INS_RESET);
            if ((inByte & `SCI_INS_GRP_MASK) == `SCI_INS_RTS) begin
                next_sum.rts = inByte[2:0];
            end
            if ((inByte & `SCI_INS_RDRX_MASK) == `SCI_INS_RDRX) begin
                next_sum.rxClr = inByte[2] ? 2'h2 : 2'h1;
            end
        end else if (lnk.phase == SCI_PH_HOLD) begin
            next_sum.resetAlone = 1'b0;
        end
    end

    always_ff @(posedge sck) begin
        sum <= next_sum;
    end

    // serial output moves on the falling edge
    always_ff @(negedge sck or posedge csN) begin
        if (csN) begin
            sdo <= 1'b0;
        end else begin
            unique case (lnk.phase)
                SCI_PH_READ: sdo <= regRdData[~lnk.bitCnt];
                SCI_PH_STAT, SCI_PH_RXST: sdo <= lnk.outByte[~lnk.bitCnt];
                default: sdo <= 1'b0;
            endcase
        end
    end

    assign sdoOeN = csN;
    assign regRdAddr = lnk.addrPtr;
    assign regWrAddr = lnk.addrPtr;
    assign regWrMask = lnk.mask;
    assign regWrData = inByte;
    assign regWrEn = (lnk.phase == SCI_PH_DATA) && lastBit;

    // system side: deselect detection and status snapshots
    always_comb begin
        next_sys = sys;
        next_sys.csSync1 = csN;
        next_sys.csSync2 = sys.csSync1;
        next_sys.csPrev = sys.csSync2;
        next_sys.sumSync1 = sum;
        next_sys.sumSync2 = sys.sumSync1;
        next_sys.softReset = 1'b0;
        next_sys.rtsSet = 3'h0;
        next_sys.rxFlagClear = 2'h0;
        next_sys.statusByte = {txBufferEmpty[2], transmitRequestBit[2],
            txBufferEmpty[1], transmitRequestBit[1], txBufferEmpty[0],
            transmitRequestBit[0], rxBufferFullFlag};
        next_sys.rxStatusByte = {rxBufferFullFlag[1], rxBufferFullFlag[0],
            1'b0, 5'h00};
        if (rxBufferFullFlag[0]) begin
            next_sys.rxStatusByte[4:0] = {rxExtended[0], rxRemote[0],
                rxFilterHitZero};
        end else if (rxBufferFullFlag[1]) begin
            next_sys.rxStatusByte[4:0] = {rxExtended[1], rxRemote[1],
                rxRollover ? {`SCI_ROLL_HI, rxFilterHitOne[0]}
                           : rxFilterHitOne};
        end
        if (modeLoad) begin
            next_sys.operatingModeField = modeRequest;
        end
        if (sys.csSync2 && !sys.csPrev) begin
            next_sys.rtsSet = sys.sumSync2.rts;
            next_sys.rxFlagClear = sys.sumSync2.rxClr;
            next_sys.softReset = sys.sumSync2.resetAlone;
            if (sys.sumSync2.resetAlone) begin
                next_sys.operatingModeField = `SCI_MODE_CONFIG;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sys <= SYS_RESET;
        end else begin
            sys <= next_sys;
        end
    end

    assign operatingModeField = sys.operatingModeField;
    assign softReset = sys.softReset;
    assign rtsSet = sys.rtsSet;
    assign rxFlagClear = sys.rxFlagClear;

endmodule : sci_spi_cmd
`default_nettype wire

/* inc/sci_defs.svh */
// constants of the spi command interpreter: instruction codes, pointer
// targets, bit-modifiable address set and reset values
// assumes a plain include by bare name
`ifndef SCI_DEFS_SVH
`define SCI_DEFS_SVH

`define SCI_INS_RESET 8'hc0
`define SCI_INS_READ 8'h03
`define SCI_INS_WRITE 8'h02
`define SCI_INS_BITMOD 8'h05
`define SCI_INS_STAT 8'ha0
`define SCI_INS_RXST 8'hb0
`define SCI_INS_RDRX 8'h90
`define SCI_INS_RDRX_MASK 8'hf9
`define SCI_INS_LDTX 8'h40
`define SCI_INS_RTS 8'h80
`define SCI_INS_GRP_MASK 8'hf8

`define SCI_PTR_ID_LO 4'h1
`define SCI_PTR_DATA_LO 4'h6
`define SCI_PTR_RX_HI 3'h3
`define SCI_PTR_TX_HI 4'h3
`define SCI_TX_SEL_BAD 2'h3

`define SCI_MASK_ALL 8'hff
`define SCI_MODE_CONFIG 3'h4

`define SCI_BM_PIN_CTRL 8'h0c
`define SCI_BM_RTS_CTRL 8'h0d
`define SCI_BM_CTRL_LO 4'hf
`define SCI_BM_CFG_FIRST 8'h28
`define SCI_BM_CFG_LAST 8'h2d
`define SCI_BM_BUF_LO 4'h0
`define SCI_BM_BUF_FIRST 4'h3
`define SCI_BM_BUF_LAST 4'h7

`define SCI_ROLL_HI 2'h3

`endif

/* inc/sci_pkg.sv */
// types of the spi command interpreter
// assumes nothing beyond a SystemVerilog compiler
package sci_pkg;

    typedef enum logic [2:0] {
        SCI_PH_CMD,
        SCI_PH_ADDR,
        SCI_PH_MASK,
        SCI_PH_DATA,
        SCI_PH_READ,
        SCI_PH_STAT,
        SCI_PH_RXST,
        SCI_PH_HOLD
    } sci_phase_t;

    typedef enum logic [1:0] {
        SCI_CMD_NONE,
        SCI_CMD_READ,
        SCI_CMD_WRITE,
        SCI_CMD_BITMOD
    } sci_cmd_t;

    // link-side state, cleared while chip select is high
    typedef struct packed {
        sci_phase_t phase;
        sci_cmd_t cmd;
        logic [2:0] bitCnt;
        logic [6:0] shift;
        logic [7:0] addrPtr;
        logic [7:0] mask;
        logic [7:0] outByte;
        logic [15:0] statSync1;
        logic [15:0] statSync2;
    } sci_link_t;

    // frame summary, kept across chip select high for the system side
    typedef struct packed {
        logic resetAlone;
        logic [2:0] rts;
        logic [1:0] rxClr;
    } sci_sum_t;

    // system-side state
    typedef struct packed {
        logic csSync1;
        logic csSync2;
        logic csPrev;
        sci_sum_t sumSync1;
        sci_sum_t sumSync2;
        logic [7:0] statusByte;
        logic [7:0] rxStatusByte;
        logic [2:0] operatingModeField;
        logic softReset;
        logic [2:0] rtsSet;
        logic [1:0] rxFlagClear;
    } sci_sys_t;

endpackage : sci_pkg
